//--- dob_line_walker.sv
// Address walker for one display buffer: one burst of dwords per go pulse.
// Assumes the consumer holds ready as a plain same-clock level.
`timescale 1ns/10ps
`default_nettype none
module dob_line_walker
  import dob_pkg::*;
#(
  parameter int unsigned CNT_W = 9
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Control from the top
  input wire logic load,
  input wire logic [OFF_W-1:0] start_off,
  input wire logic go,
  input wire logic [CNT_W-1:0] count,
  input wire logic [OFF_W-1:0] step,
  input wire logic [BASE_W-1:0] base,
  // Fetch request
  input wire logic req_ready,
  output logic req_valid,
  output logic [31:0] req_addr
);

  dob_walk_state_t st_r, st_nxt; // Burst state
  logic [OFF_W-1:0] line_off_r, line_off_nxt; // Start of next line
  logic [OFF_W-1:0] cur_off_r, cur_off_nxt; // Next dword to ask for
  logic [CNT_W-1:0] left_r, left_nxt; // Dwords still to ask for
  logic valid_r, valid_nxt;
  logic [31:0] addr_r, addr_nxt;

  // Source offset: a load in the same cycle wins
  wire [OFF_W-1:0] src = load ? start_off : line_off_r;
  // Output slot is free when empty or being taken
  wire slot = !valid_r || req_ready;
  wire issue = (st_r == WK_BURST) && slot && (left_r != '0);

  // Next-state decode
  always_comb begin
    st_nxt = st_r;
    line_off_nxt = load ? start_off : line_off_r;
    cur_off_nxt = cur_off_r;
    left_nxt = left_r;
    valid_nxt = valid_r && !req_ready;
    addr_nxt = addr_r;
    if (go) begin
      // New line; stepping by the programmed delta
      line_off_nxt = src + step;
      cur_off_nxt = src;
      left_nxt = count;
      st_nxt = WK_BURST;
    end else begin
      case (st_r)
        WK_IDLE: begin
          // Nothing to ask for until the next go
          st_nxt = WK_IDLE;
        end
        WK_BURST: begin
          if (issue) begin
            // Contiguous dwords inside the line
            valid_nxt = 1'b1;
            addr_nxt = dob_aperture_addr(base, cur_off_r);
            cur_off_nxt = cur_off_r + DWORD_BYTES;
            left_nxt = left_r - 1'b1;
          end else if (left_r == '0 && slot) begin
            // Last request taken; wait for the next go
            st_nxt = WK_IDLE;
          end
        end
        default: begin
          st_nxt = WK_IDLE;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= WK_IDLE;
      line_off_r <= '0;
      cur_off_r <= '0;
      left_r <= '0;
      valid_r <= 1'b0;
      addr_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      line_off_r <= line_off_nxt;
      cur_off_r <= cur_off_nxt;
      left_r <= left_nxt;
      valid_r <= valid_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign req_valid = valid_r;
  assign req_addr = addr_r;

endmodule
`default_nettype wire

//--- dob_mem_model.sv
// Far side model: memory answers for the three fetch ports.
// Assumes the bench picks prompt or stalled answers through slow.
`timescale 1ns/10ps
`default_nettype none
module dob_mem_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Answer mode
  input wire logic slow,
  // Fetch answers
  output logic fb_ready,
  output logic cb_ready,
  output logic cur_ready
);
  logic ph_r; // Stall phase
  // Stalled mode takes only every other cycle, so holds get exercised
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
    end
  end
  assign fb_ready = !slow || ph_r;
  assign cb_ready = !slow || !ph_r;
  assign cur_ready = !slow || ph_r;
endmodule
`default_nettype wire

//--- dob_pkg.sv
// Constants, carriers and helpers for the display output and buffer layout block.
// Assumes a 100 MHz core clock and a register port decoded from the graphics register base.
package dob_pkg;

  // Register port widths
  localparam int unsigned REG_AW = 16;
  localparam int unsigned REG_DW = 32;

  // Register offsets from the graphics register base
  localparam logic [15:0] OFS_OUT_CFG = 16'h830C;
  localparam logic [15:0] OFS_FB_START = 16'h8310;
  localparam logic [15:0] OFS_CB_START = 16'h8314;
  localparam logic [15:0] OFS_CUR_START = 16'h8318;
  localparam logic [15:0] OFS_LINE_DELTA = 16'h8324;
  localparam logic [15:0] OFS_LINE_SIZE = 16'h8328;
  localparam logic [15:0] OFS_STATUS = 16'h8330;

  // Output configuration field positions
  localparam int unsigned BIT_UPPER_EN = 13;
  localparam int unsigned BIT_LOWER_EN = 12;
  localparam int unsigned BIT_PCLK_EN = 2;
  localparam int unsigned BIT_PACK_555 = 1;
  localparam int unsigned BIT_DEPTH_8 = 0;

  // Writable bits; the rest read as zero
  localparam logic [31:0] OUT_CFG_MASK = 32'h0000_3007;
  localparam logic [31:0] OFS_MASK = 32'h003F_FFFF;

  // Values after reset
  localparam logic [31:0] RST_OUT_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_OFS = 32'h0000_0000;

  // Aperture: 4 MB means 22 offset bits
  localparam int unsigned OFF_W = 22;
  localparam int unsigned BASE_W = 10;
  localparam logic [21:0] DWORD_BYTES = 22'h00_0004;

  // Line delta and line size field layout
  localparam int unsigned DELTA_FB_LSB = 0;
  localparam int unsigned DELTA_CB_LSB = 16;
  localparam int unsigned DELTA_W = 16;
  localparam int unsigned SIZE_FB_LSB = 0;
  localparam int unsigned SIZE_CB_LSB = 16;
  localparam int unsigned SIZE_W = 9;

  // Pixel bus layout
  localparam int unsigned PIX_W = 18;
  localparam int unsigned UPPER_HI = 17;
  localparam int unsigned UPPER_LO = 9;
  localparam int unsigned LOWER_HI = 8;

  // Register request carrier
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dob_reg_req_t;

  // Fetch walker states
  typedef enum logic {WK_IDLE, WK_BURST} dob_walk_state_t;

  // Memory address: aperture base plus byte offset
  function automatic logic [31:0] dob_aperture_addr(input logic [BASE_W-1:0] base,
                                                    input logic [OFF_W-1:0] off);
    dob_aperture_addr = {base, 22'h00_0000} + {10'h000, off};
  endfunction

endpackage

//--- dob_top.sv
// Display pixel output configuration and graphics memory layout registers.
// Assumes frame and line strobes from a timing generator on the same clock,
// a pixel source that holds data until taken, and a fetch consumer with ready.
`timescale 1ns/10ps
`default_nettype none
module dob_top
  import dob_pkg::*;
#(
  parameter int unsigned PCLK_DIV = 4, // Core cycles per pixel clock, even
  parameter int unsigned CUR_DWORDS = 64, // Cursor pattern length
  parameter int unsigned CNT_W = 9 // Width of dword counts
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire dob_reg_req_t reg_req,
  input wire logic reg_lock,
  output logic [REG_DW-1:0] reg_rdata,
  // Memory controller and timing
  input wire logic [BASE_W-1:0] graphics_base_field,
  input wire logic frame_start,
  input wire logic line_start,
  // Pixel source
  input wire logic pix_valid,
  input wire logic [15:0] pix_data,
  output logic pix_take,
  // Pixel port
  output logic [PIX_W-1:0] pixel_bus,
  output logic pixel_clock_out,
  // Frame buffer fetch
  input wire logic fb_req_ready,
  output logic fb_req_valid,
  output logic [31:0] fb_req_addr,
  // Compressed buffer fetch
  input wire logic cb_req_ready,
  output logic cb_req_valid,
  output logic [31:0] cb_req_addr,
  // Cursor fetch
  input wire logic cur_req_ready,
  output logic cur_req_valid,
  output logic [31:0] cur_req_addr
);

  // Divider width and phase points; an odd divider would skew the duty cycle
  localparam int unsigned DIV_W = $clog2(PCLK_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PCLK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(PCLK_DIV / 2);
  localparam logic [CNT_W-1:0] CUR_CNT = CNT_W'(CUR_DWORDS);

  // Register file
  logic [31:0] out_cfg_r; // Output configuration
  logic [31:0] fb_start_r; // Frame buffer start offset
  logic [31:0] cb_start_r; // Compressed buffer start offset
  logic [31:0] cur_start_r; // Cursor start offset
  logic [31:0] delta_r; // Line deltas, both buffers
  logic [31:0] size_r; // Dwords per line, both buffers
  logic [31:0] rdata_r; // Read answer
  logic [BASE_W-1:0] base_r; // Base caught at frame start
  logic [15:0] line_cnt_r; // Lines since frame start

  // Pixel path
  logic [DIV_W-1:0] div_r; // Pixel clock divider
  logic pclk_r; // Off-chip pixel clock
  logic [PIX_W-1:0] fmt_r; // Last formatted pixel
  logic [PIX_W-1:0] bus_r; // Gated pixel bus
  logic take_r; // Pixel consumed pulse

  // Format one source word onto the 6-6-6 bus
  function automatic logic [PIX_W-1:0] dob_format(input logic [15:0] d,
                                                  input logic depth8,
                                                  input logic pack555);
    if (depth8) begin
      // Index passes on the low byte; packing is moot here
      dob_format = {10'h000, d[7:0]};
    end else if (pack555) begin
      // All three fields widened by copying their top bit
      dob_format = {d[14:10], d[14], d[9:5], d[9], d[4:0], d[4]};
    end else begin
      dob_format = {d[15:11], d[15], d[10:5], d[4:0], d[4]};
    end
  endfunction

  // Register address decode
  // Full 16-bit compare; offsets outside the map read zero
  wire hit_cfg = reg_req.addr == OFS_OUT_CFG;
  wire hit_fb = reg_req.addr == OFS_FB_START;
  wire hit_cb = reg_req.addr == OFS_CB_START;
  wire hit_cur = reg_req.addr == OFS_CUR_START;
  wire hit_delta = reg_req.addr == OFS_LINE_DELTA;
  wire hit_size = reg_req.addr == OFS_LINE_SIZE;
  wire hit_stat = reg_req.addr == OFS_STATUS;
  // Writes are dropped while the display lock holds
  wire wr_ok = reg_req.wr && !reg_lock;

  // Configuration fields
  wire depth8 = out_cfg_r[BIT_DEPTH_8];
  wire pack555 = out_cfg_r[BIT_PACK_555];
  wire pclk_en = out_cfg_r[BIT_PCLK_EN];
  wire upper_pixel_bus_enable = out_cfg_r[BIT_UPPER_EN];
  wire lower_pixel_bus_enable = out_cfg_r[BIT_LOWER_EN];

  // Layout fields
  wire [OFF_W-1:0] frame_start_field = fb_start_r[OFF_W-1:0];
  wire [OFF_W-1:0] cb_start_field = cb_start_r[OFF_W-1:0];
  // Offsets are 22 bits, so no buffer can reach past 4 MB
  wire [OFF_W-1:0] cur_start_field = cur_start_r[OFF_W-1:0];
  wire [OFF_W-1:0] fb_delta = {6'h00, delta_r[DELTA_FB_LSB +: DELTA_W]};
  wire [OFF_W-1:0] cb_delta = {6'h00, delta_r[DELTA_CB_LSB +: DELTA_W]};
  wire [CNT_W-1:0] fb_dwords = CNT_W'(size_r[SIZE_FB_LSB +: SIZE_W]);
  wire [CNT_W-1:0] cb_dwords = CNT_W'(size_r[SIZE_CB_LSB +: SIZE_W]);

  // Block state seen by software
  // Line count is for software only; it wraps after 65535 lines
  wire [31:0] status_word = {line_cnt_r, 13'h0000, cur_req_valid, cb_req_valid,
                             fb_req_valid};

  // Read selection; unmapped and reserved offsets read zero
  wire [31:0] rd_mux = hit_cfg ? out_cfg_r :
                       hit_fb ? fb_start_r :
                       hit_cb ? cb_start_r :
                       hit_cur ? cur_start_r :
                       hit_delta ? delta_r :
                       hit_size ? size_r :
                       hit_stat ? status_word : 32'h0000_0000;

  // Pixel divider phases
  // The clock output is high for the upper half of each pixel period
  wire div_wrap = div_r == DIV_LAST;
  wire pclk_phase = div_r >= DIV_HALF;
  // New pixel on each divider wrap, when one is offered
  wire pix_load = div_wrap && pix_valid;

  // Bus halves, each forced low while its enable is clear
  wire [8:0] upper_half = upper_pixel_bus_enable ? fmt_r[UPPER_HI:UPPER_LO] : 9'h000;
  wire [8:0] lower_half = lower_pixel_bus_enable ? fmt_r[LOWER_HI:0] : 9'h000;

  // Configuration and offset registers; offsets keep 22 bits
  // Reserved bits are masked on the way in, so they always read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_cfg_r <= RST_OUT_CFG;
      fb_start_r <= RST_OFS;
      cb_start_r <= RST_OFS;
      cur_start_r <= RST_OFS;
    end else if (ce && wr_ok) begin
      if (hit_cfg) out_cfg_r <= reg_req.wdata & OUT_CFG_MASK;
      // Live rewrite is safe; it lands at the next frame
      if (hit_fb) fb_start_r <= reg_req.wdata & OFS_MASK;
      if (hit_cb) cb_start_r <= reg_req.wdata & OFS_MASK;
      if (hit_cur) cur_start_r <= reg_req.wdata & OFS_MASK;
    end
  end

  // Line geometry registers
  // Size bits beyond nine per buffer are dropped, bounding each burst
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      delta_r <= RST_OFS;
      size_r <= RST_OFS;
    end else if (ce && wr_ok) begin
      if (hit_delta) delta_r <= reg_req.wdata;
      if (hit_size) size_r <= {7'h00, reg_req.wdata[24:16], 7'h00,
                               reg_req.wdata[8:0]};
    end
  end

  // Read data stand only in the cycle after the strobe
  // Idle cycles read zero, so a stale word never passes for an answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      rdata_r <= reg_req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Base and line count follow the frame
  // A frame strobe beside a line strobe wins; the count clears and that line is not counted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= '0;
      line_cnt_r <= 16'h0000;
    end else if (ce) begin
      // Base held a whole frame so a buffer never straddles two bases
      if (frame_start) base_r <= graphics_base_field;
      if (frame_start) line_cnt_r <= 16'h0000;
      else if (line_start) line_cnt_r <= line_cnt_r + 16'h0001;
    end
  end

  // Pixel clock divider and gated clock out
  // The divider runs while the output is gated, so enabling keeps phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      pclk_r <= 1'b0;
    end else if (ce) begin
      div_r <= div_wrap ? '0 : div_r + 1'b1;
      // Held low while disabled
      pclk_r <= pclk_en && pclk_phase;
    end
  end

  // Pixel capture, formatting and output gating
  // Without a new pixel at a wrap the last one stays on the bus
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fmt_r <= '0;
      bus_r <= '0;
      take_r <= 1'b0;
    end else if (ce) begin
      // Data change near the clock's falling edge, stable at rising
      if (pix_load) fmt_r <= dob_format(pix_data, depth8, pack555);
      take_r <= pix_load;
      // Enabled halves carry the formatted pixel
      bus_r <= {upper_half, lower_half};
    end
  end

  // Frame buffer: a line per line strobe from its own offset
  // Frame and line strobes may coincide; the load then feeds the first line
  dob_line_walker #(
    .CNT_W(CNT_W)
  ) u_fb_walk (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .load(frame_start),
    .start_off(frame_start_field),
    .go(line_start),
    .count(fb_dwords),
    .step(fb_delta),
    .base(base_r),
    .req_ready(fb_req_ready),
    .req_valid(fb_req_valid),
    .req_addr(fb_req_addr)
  );

  // Compressed buffer: same line scheme, own offset and delta
  // A zero dword count leaves this walker idle for the whole frame
  dob_line_walker #(
    .CNT_W(CNT_W)
  ) u_cb_walk (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .load(frame_start),
    .start_off(cb_start_field),
    .go(line_start),
    .count(cb_dwords),
    .step(cb_delta),
    .base(base_r),
    .req_ready(cb_req_ready),
    .req_valid(cb_req_valid),
    .req_addr(cb_req_addr)
  );

  // Cursor: one linear block per frame, no line stepping
  // Zero step: the block is one burst, never split into lines
  dob_line_walker #(
    .CNT_W(CNT_W)
  ) u_cur_walk (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .load(frame_start),
    .start_off(cur_start_field),
    .go(frame_start),
    .count(CUR_CNT),
    .step(22'h00_0000),
    .base(base_r),
    .req_ready(cur_req_ready),
    .req_valid(cur_req_valid),
    .req_addr(cur_req_addr)
  );

  // Outputs straight from registers
  // No decode sits between a flip-flop and a pin, so pins never glitch
  assign reg_rdata = rdata_r;
  assign pix_take = take_r;
  assign pixel_bus = bus_r;
  assign pixel_clock_out = pclk_r;

endmodule
`default_nettype wire

//--- dob_top_bench.sv
// Self-checking bench for dob_top with a short cursor.
// Assumes dob_mem_model answers fetches and the monitor is bound in.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module dob_top_bench;
  import dob_pkg::*;
  localparam int unsigned DIV = 4; // Pixel divider
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  dob_reg_req_t reg_req = '0;
  logic reg_lock = 1'b0;
  logic [BASE_W-1:0] gbase = '0;
  logic frame_start = 1'b0;
  logic line_start = 1'b0;
  logic pix_valid = 1'b0;
  logic [15:0] pix_data = 16'h0000;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic [REG_DW-1:0] rdata;
  logic [PIX_W-1:0] pbus;
  logic pclk, take, fb_r, cb_r, cur_r, fb_v, cb_v, cur_v;
  logic [31:0] fb_a, cb_a, cur_a;
  logic [31:0] fbq[$]; // Accepted frame fetches
  logic [31:0] curq[$]; // Accepted cursor fetches
  logic [31:0] cbq[$]; // Accepted compressed fetches
  logic [31:0] cfg_tab [7] = '{32'h0000_3001, 32'h0000_3003, 32'h0000_3004,
    32'h0000_3006, 32'h0000_2004, 32'h0000_1000, 32'h0000_0000};
  int fail_count = 0;
  int checks_done = 0;
  always #5 clock = ~clock;
  dob_top #(.PCLK_DIV(DIV), .CUR_DWORDS(4), .CNT_W(9)) i_dut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_lock(reg_lock),
    .reg_rdata(rdata), .graphics_base_field(gbase), .frame_start(frame_start),
    .line_start(line_start), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_take(take), .pixel_bus(pbus), .pixel_clock_out(pclk),
    .fb_req_ready(fb_r), .fb_req_valid(fb_v), .fb_req_addr(fb_a),
    .cb_req_ready(cb_r), .cb_req_valid(cb_v), .cb_req_addr(cb_a),
    .cur_req_ready(cur_r), .cur_req_valid(cur_v), .cur_req_addr(cur_a));
  dob_mem_model i_mem (.clock(clock), .rst_n(rst_n), .slow(slow),
    .fb_ready(fb_r), .cb_ready(cb_r), .cur_ready(cur_r));
  // Record every accepted fetch address before the edge updates land
  always @(posedge clock) begin
    if (fb_v && fb_r) fbq.push_back(fb_a);
    if (cur_v && cur_r) curq.push_back(cur_a);
    if (cb_v && cb_r) cbq.push_back(cb_a);
  end
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    reg_req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    reg_req.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic t_regs();
    rd(OFS_OUT_CFG, RST_OUT_CFG);
    rd(OFS_FB_START, RST_OFS);
    wr(OFS_OUT_CFG, 32'hFFFF_FFFF);
    rd(OFS_OUT_CFG, 32'h0000_3007);
    wr(OFS_FB_START, 32'hFFFF_FFFF);
    rd(OFS_FB_START, 32'h003F_FFFF);
    @(posedge clock) reg_lock <= 1'b1;
    wr(OFS_FB_START, 32'h0000_0000);
    rd(OFS_FB_START, 32'h003F_FFFF);
    @(posedge clock) reg_lock <= 1'b0;
    wr(16'h831C, 32'hFFFF_FFFF);
    rd(16'h831C, 32'h0000_0000);
    rd(16'h8320, 32'h0000_0000);
    wr(OFS_LINE_SIZE, 32'hFFFF_FFFF);
    rd(OFS_LINE_SIZE, 32'h01FF_01FF);
  endtask
  // Clock enable low freezes the divider and drops register writes
  task automatic t_hold();
    logic p;
    @(posedge clock) ce <= 1'b0;
    wr(OFS_FB_START, 32'h0000_0000);
    #1 p = pclk;
    repeat (6) @(posedge clock);
    #1 `CHK(pclk, p)
    @(posedge clock) ce <= 1'b1;
    rd(OFS_FB_START, 32'h003F_FFFF);
  endtask
  // Expected bus word: widen 5-bit fields by repeating the top bit
  function automatic logic [PIX_W-1:0] fmt(input logic [15:0] d, input logic [31:0] c);
    logic [5:0] r, g;
    r = c[1] ? {d[14:10], d[14]} : {d[15:11], d[15]};
    g = c[1] ? {d[9:5], d[9]} : d[10:5];
    fmt = c[0] ? {10'h000, d[7:0]} : {r, g, d[4:0], d[4]};
    if (!c[13]) fmt[17:9] = 9'h000;
    if (!c[12]) fmt[8:0] = 9'h000;
  endfunction
  task automatic wait_take();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (take !== 1'b1 && n < 20);
    `CHK(take, 1'b1)
  endtask
  task automatic t_pix(input logic [31:0] c);
    int n;
    logic p;
    wr(OFS_OUT_CFG, c);
    repeat (2) wait_take();
    @(posedge clock);
    #1 `CHK(pbus, fmt(pix_data, c))
    n = 0;
    p = pclk;
    repeat (4 * DIV) begin
      @(posedge clock);
      #1 if (pclk && !p) n++;
      p = pclk;
    end
    `CHK(n, c[2] ? 4 : 0)
    if (!c[2]) `CHK(pclk, 1'b0)
  endtask
  // One frame: start line plus one more line, with the cursor block fetched from the frame start
  task automatic t_fetch(input logic [31:0] st, input logic sl);
    logic [31:0] bs;
    logic [31:0] fe [4];
    bs = {10'h2A5, 22'h0};
    fe = '{st, st + 32'h4, st + 32'h40, st + 32'h44};
    wr(OFS_FB_START, st);
    @(posedge clock);
    fbq.delete();
    curq.delete();
    cbq.delete();
    gbase <= 10'h2A5;
    slow <= sl;
    frame_start <= 1'b1;
    line_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    line_start <= 1'b0;
    repeat (30) @(posedge clock);
    line_start <= 1'b1;
    @(posedge clock);
    line_start <= 1'b0;
    repeat (30) @(posedge clock);
    `CHK(fbq.size(), 4)
    `CHK(curq.size(), 4)
    for (int i = 0; i < 4; i++) begin
      `CHK(fbq[i], bs + fe[i])
      `CHK(curq[i], bs + 32'h200 + 32'(4 * i))
    end
    `CHK(cbq.size(), 2)
    `CHK(cbq[0], bs + 32'h1000)
    `CHK(cbq[1], bs + 32'h1080)
    rd(OFS_STATUS, 32'h0001_0000);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_hold();
    @(posedge clock);
    pix_valid <= 1'b1;
    pix_data <= 16'hA5C3;
    foreach (cfg_tab[i]) t_pix(cfg_tab[i]);
    wr(OFS_CUR_START, 32'h0000_0200);
    wr(OFS_CB_START, 32'h0000_1000);
    wr(OFS_LINE_DELTA, 32'h0080_0040);
    wr(OFS_LINE_SIZE, 32'h0001_0002);
    t_fetch(32'h0000_0100, 1'b1);
    t_fetch(32'h0000_0800, 1'b0);
    end_of_test();
  end
  // Run needs about 380 cycles; cut a hang at about forty times that
  initial begin
    #150000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

//--- dob_top_monitor.sv
// Checker for the display output block, bound into every dob_top.
// Assumes the register port and clock enable follow the hand-over contract.
`timescale 1ns/10ps
`default_nettype none
module dob_top_monitor
  import dob_pkg::*;
#(
  parameter int unsigned PCLK_DIV = 4, // Pixel clock divider
  parameter int unsigned CUR_DWORDS = 64, // Cursor length
  parameter int unsigned CNT_W = 9 // Count width
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire dob_reg_req_t reg_req,
  input wire logic reg_lock,
  input wire logic [REG_DW-1:0] reg_rdata,
  // Timing and base
  input wire logic [BASE_W-1:0] graphics_base_field,
  input wire logic frame_start,
  input wire logic line_start,
  // Pixel port
  input wire logic [PIX_W-1:0] pixel_bus,
  input wire logic pixel_clock_out,
  // Fetch ports
  input wire logic fb_req_ready,
  input wire logic fb_req_valid,
  input wire logic [31:0] fb_req_addr,
  input wire logic cur_req_ready,
  input wire logic cur_req_valid,
  input wire logic [31:0] cur_req_addr
);
  default clocking cb_mon @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [31:0] cfg_s; // Shadow of the output config
  logic [BASE_W-1:0] base_s; // Base taken at frame start
  wire cfg_wr = ce && reg_req.wr && !reg_lock && reg_req.addr == OFS_OUT_CFG;
  wire rd_on = ce && reg_req.rd;
  wire go_now = frame_start || line_start;
  // Shadows follow the port, so checks never peek inside
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s <= RST_OUT_CFG;
      base_s <= '0;
    end else begin
      if (cfg_wr) cfg_s <= reg_req.wdata & OUT_CFG_MASK;
      if (ce && frame_start) base_s <= graphics_base_field;
    end
  end
  property p_upper_off;
    !cfg_s[BIT_UPPER_EN] |=> pixel_bus[17:9] == 9'h000;
  endproperty
  a_upper_off: assert property (p_upper_off)
    else $error("upper pixel half not low");
  property p_lower_off;
    !cfg_s[BIT_LOWER_EN] |=> pixel_bus[8:0] == 9'h000;
  endproperty
  a_lower_off: assert property (p_lower_off)
    else $error("lower pixel half not low");
  property p_pclk_off;
    !cfg_s[BIT_PCLK_EN] |=> !pixel_clock_out;
  endproperty
  a_pclk_off: assert property (p_pclk_off)
    else $error("pixel clock runs while off");
  property p_cfg_read;
    rd_on && reg_req.addr == OFS_OUT_CFG |=> reg_rdata == $past(cfg_s);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("output config read wrong");
  property p_hole_read;
    rd_on && (reg_req.addr == 16'h831C || reg_req.addr == 16'h8320) |=> reg_rdata == 32'h0;
  endproperty
  a_hole_read: assert property (p_hole_read)
    else $error("unused offset reads nonzero");
  property p_fb_top;
    rd_on && reg_req.addr == OFS_FB_START |=> reg_rdata[31:22] == 10'h000;
  endproperty
  a_fb_top: assert property (p_fb_top)
    else $error("frame start upper bits set");
  property p_cur_base;
    cur_req_valid |-> cur_req_addr[31:22] == base_s;
  endproperty
  a_cur_base: assert property (p_cur_base)
    else $error("cursor fetch outside aperture");
  property p_cur_step;
    cur_req_valid && cur_req_ready && !frame_start && !$past(frame_start)
      ##1 cur_req_valid |-> cur_req_addr == $past(cur_req_addr) + 32'h4;
  endproperty
  a_cur_step: assert property (p_cur_step)
    else $error("cursor fetch not linear");
  property p_fb_hold;
    fb_req_valid && !fb_req_ready && !go_now && !$past(go_now)
      |=> fb_req_valid && $stable(fb_req_addr);
  endproperty
  a_fb_hold: assert property (p_fb_hold)
    else $error("frame fetch dropped before ready");
endmodule
bind dob_top dob_top_monitor #(.PCLK_DIV(PCLK_DIV), .CUR_DWORDS(CUR_DWORDS), .CNT_W(CNT_W)) i_mon (
  .clock(clock), .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_lock(reg_lock),
  .reg_rdata(reg_rdata), .graphics_base_field(graphics_base_field),
  .frame_start(frame_start), .line_start(line_start), .pixel_bus(pixel_bus),
  .pixel_clock_out(pixel_clock_out), .fb_req_ready(fb_req_ready),
  .fb_req_valid(fb_req_valid), .fb_req_addr(fb_req_addr), .cur_req_ready(cur_req_ready),
  .cur_req_valid(cur_req_valid), .cur_req_addr(cur_req_addr)
);
`default_nettype wire
